//--- rtl/pio_consts.vh
// Register map, widths and reset values of the parallel I/O port bank
//
// Contract
// - Seven two-way ports; each implemented pin set individually as input or output.
// - Ports A, C, D and F have per-bit pullups, active only on inputs.
// - Output direction switches the pullup off; returning to input restores it.
// - Reset clears every direction register, so all pins start as inputs.
// - Reset leaves the port data latches untouched.
// - Unimplemented bits read zero and ignore writes.
// - A, B, D, F, G are eight bits; C seven bits; E six bits.
// - Pullup enable registers hold one bit per pin and reset to zero.
// - Registers decode at fixed offsets 0x0000-0x000f and 0x0440-0x0448.
// - Converter channel select forces its shared pin to input and its pullup off; latch and direction register unchanged.
`ifndef PIO_CONSTS_VH
`define PIO_CONSTS_VH

// ****************************************************************
// Register indices, byte address is four times the index
// ****************************************************************
`define PIO_IDX_W           14
`define PIO_IDX_A_DATA      14'h0000
`define PIO_IDX_B_DATA      14'h0001
`define PIO_IDX_C_DATA      14'h0002
`define PIO_IDX_D_DATA      14'h0003
`define PIO_IDX_A_DIR       14'h0004
`define PIO_IDX_B_DIR       14'h0005
`define PIO_IDX_C_DIR       14'h0006
`define PIO_IDX_D_DIR       14'h0007
`define PIO_IDX_E_DATA      14'h0008
`define PIO_IDX_E_DIR       14'h000c
`define PIO_IDX_A_PU        14'h000d
`define PIO_IDX_C_PU        14'h000e
`define PIO_IDX_D_PU        14'h000f
`define PIO_IDX_F_DATA      14'h0440
`define PIO_IDX_G_DATA      14'h0441
`define PIO_IDX_F_DIR       14'h0444
`define PIO_IDX_G_DIR       14'h0445
`define PIO_IDX_F_PU        14'h0448

// ****************************************************************
// Port widths and reset values
// ****************************************************************
`define PIO_WIDTH_FULL      8
`define PIO_WIDTH_C         7
`define PIO_WIDTH_E         6
`define PIO_DIR_RESET       8'h00
`define PIO_PU_RESET        8'h00

// ****************************************************************
// Converter channel bases of the shared ports
// ****************************************************************
`define PIO_CONV_BASE_B     5'h00
`define PIO_CONV_BASE_A     5'h08
`define PIO_CONV_BASE_G     5'h10

`endif

//--- rtl/pio_conv_decode.v
// Converter channel select decoded into per-port pin override masks
module pio_conv_decode (
    // Converter control
    input  wire       conv_enable_i,
    input  wire [4:0] conv_channel_i,
    // Override masks
    output wire [7:0] ovr_a_o,
    output wire [7:0] ovr_b_o,
    output wire [7:0] ovr_g_o
);
`include "pio_consts.vh"

    // ****************************************************************
    // Channel to one-hot mask within one eight-pin group
    // ****************************************************************
    function [7:0] pio_chan_mask;
        input       en;
        input [4:0] chan;
        input [4:0] base;
        begin
            pio_chan_mask = 8'h00;
            if (en && chan[4:3] == base[4:3]) begin
                pio_chan_mask[chan[2:0]] = 1'b1;
            end
        end
    endfunction

    assign ovr_a_o = pio_chan_mask(conv_enable_i, conv_channel_i, `PIO_CONV_BASE_A);
    assign ovr_b_o = pio_chan_mask(conv_enable_i, conv_channel_i, `PIO_CONV_BASE_B);
    assign ovr_g_o = pio_chan_mask(conv_enable_i, conv_channel_i, `PIO_CONV_BASE_G);

endmodule

//--- rtl/pio_port.v
// One parallel port: data latch, direction, pullup enable and pin logic
module pio_port #(
    parameter WIDTH      = 8,
    parameter HAS_PULLUP = 1
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // Register writes
    input  wire             wr_latch_i,
    input  wire             wr_dir_i,
    input  wire             wr_pu_i,
    input  wire [7:0]       wdata_i,
    // Converter override
    input  wire [WIDTH-1:0] override_i,
    // Pins
    input  wire [WIDTH-1:0] pin_i,
    output reg  [WIDTH-1:0] pin_o,
    output reg  [WIDTH-1:0] pin_oe_o,
    output reg  [WIDTH-1:0] pullup_o,
    // Register reads
    output wire [7:0]       rd_data_o,
    output wire [7:0]       rd_dir_o,
    output wire [7:0]       rd_pu_o
);
`include "pio_consts.vh"

    reg  [WIDTH-1:0] latch;
    reg  [WIDTH-1:0] dir_bits;
    reg  [WIDTH-1:0] pu_bits;
    reg  [WIDTH-1:0] pin_meta;
    reg  [WIDTH-1:0] pin_sync;
    wire [WIDTH-1:0] data_view;
    reg  [7:0]       data_ext;
    reg  [7:0]       dir_ext;
    reg  [7:0]       pu_ext;

    localparam [7:0] DIR_RST = `PIO_DIR_RESET;
    localparam [7:0] PU_RST  = `PIO_PU_RESET;

    // ****************************************************************
    // Registers
    // ****************************************************************
    always @(posedge clk_i) begin
        if (wr_latch_i) begin
            latch <= wdata_i[WIDTH-1:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            dir_bits <= DIR_RST[WIDTH-1:0];
            pu_bits  <= PU_RST[WIDTH-1:0];
        end else begin
            if (wr_dir_i) begin
                dir_bits <= wdata_i[WIDTH-1:0];
            end
            if (wr_pu_i && HAS_PULLUP != 0) begin
                pu_bits <= wdata_i[WIDTH-1:0];
            end
        end
    end

    // ****************************************************************
    // Pin synchroniser and outputs
    // ****************************************************************
    always @(posedge clk_i) begin
        pin_meta <= pin_i;
        pin_sync <= pin_meta;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_o    <= {WIDTH{1'b0}};
            pin_oe_o <= {WIDTH{1'b0}};
            pullup_o <= {WIDTH{1'b0}};
        end else begin
            pin_o    <= latch;
            pin_oe_o <= dir_bits & ~override_i;
            pullup_o <= pu_bits & ~dir_bits & ~override_i;
        end
    end

    // ****************************************************************
    // Read views, unimplemented bits zero
    // ****************************************************************
    assign data_view = (dir_bits & latch) | (~dir_bits & pin_sync);
    always @* begin
        data_ext = 8'h00;
        dir_ext  = 8'h00;
        pu_ext   = 8'h00;
        data_ext[WIDTH-1:0] = data_view;
        dir_ext[WIDTH-1:0]  = dir_bits;
        if (HAS_PULLUP != 0) begin
            pu_ext[WIDTH-1:0] = pu_bits;
        end
    end

    assign rd_data_o = data_ext;
    assign rd_dir_o  = dir_ext;
    assign rd_pu_o   = pu_ext;

endmodule

//--- rtl/pio_top.v
// Parallel I/O port bank with a classic Wishbone register slave
//
// The Wishbone interface to the registers was chosen for this implementation.
module pio_top (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [15:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Converter channel select
    input  wire        conv_enable_i,
    input  wire [4:0]  conv_channel_i,
    // Port A pins
    input  wire [7:0]  port_a_pin_i,
    output wire [7:0]  port_a_pin_o,
    output wire [7:0]  port_a_pin_oe_o,
    output wire [7:0]  port_a_pullup_o,
    // Port B pins
    input  wire [7:0]  port_b_pin_i,
    output wire [7:0]  port_b_pin_o,
    output wire [7:0]  port_b_pin_oe_o,
    // Port C pins
    input  wire [6:0]  port_c_pin_i,
    output wire [6:0]  port_c_pin_o,
    output wire [6:0]  port_c_pin_oe_o,
    output wire [6:0]  port_c_pullup_o,
    // Port D pins
    input  wire [7:0]  port_d_pin_i,
    output wire [7:0]  port_d_pin_o,
    output wire [7:0]  port_d_pin_oe_o,
    output wire [7:0]  port_d_pullup_o,
    // Port E pins
    input  wire [5:0]  port_e_pin_i,
    output wire [5:0]  port_e_pin_o,
    output wire [5:0]  port_e_pin_oe_o,
    // Port F pins
    input  wire [7:0]  port_f_pin_i,
    output wire [7:0]  port_f_pin_o,
    output wire [7:0]  port_f_pin_oe_o,
    output wire [7:0]  port_f_pullup_o,
    // Port G pins
    input  wire [7:0]  port_g_pin_i,
    output wire [7:0]  port_g_pin_o,
    output wire [7:0]  port_g_pin_oe_o
);
`include "pio_consts.vh"

    wire                  req;
    wire                  wr_en;
    wire [`PIO_IDX_W-1:0] idx;
    wire [7:0]            wdata;
    wire [7:0]            ovr_a;
    wire [7:0]            ovr_b;
    wire [7:0]            ovr_g;
    wire [7:0]            a_data;
    wire [7:0]            a_dir;
    wire [7:0]            a_pu;
    wire [7:0]            b_data;
    wire [7:0]            b_dir;
    wire [7:0]            c_data;
    wire [7:0]            c_dir;
    wire [7:0]            c_pu;
    wire [7:0]            d_data;
    wire [7:0]            d_dir;
    wire [7:0]            d_pu;
    wire [7:0]            e_data;
    wire [7:0]            e_dir;
    wire [7:0]            f_data;
    wire [7:0]            f_dir;
    wire [7:0]            f_pu;
    wire [7:0]            g_data;
    wire [7:0]            g_dir;
    reg  [7:0]            next_rdata;

    // ****************************************************************
    // Bus request decode
    // ****************************************************************
    assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en = req & wb_we_i & wb_sel_i[0];
    assign idx   = wb_adr_i[15:2];
    assign wdata = wb_dat_i[7:0];

    function pio_wr;
        input                  en;
        input [`PIO_IDX_W-1:0] at;
        input [`PIO_IDX_W-1:0] reg_idx;
        begin
            pio_wr = en && (at == reg_idx);
        end
    endfunction

    // ****************************************************************
    // Converter override masks
    // ****************************************************************
    pio_conv_decode u_conv (
        .conv_enable_i  (conv_enable_i),
        .conv_channel_i (conv_channel_i),
        .ovr_a_o        (ovr_a),
        .ovr_b_o        (ovr_b),
        .ovr_g_o        (ovr_g)
    );

    // ****************************************************************
    // Ports
    // ****************************************************************
    pio_port #(.WIDTH(`PIO_WIDTH_FULL), .HAS_PULLUP(1)) u_port_a (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wr_latch_i (pio_wr(wr_en, idx, `PIO_IDX_A_DATA)),
        .wr_dir_i   (pio_wr(wr_en, idx, `PIO_IDX_A_DIR)),
        .wr_pu_i    (pio_wr(wr_en, idx, `PIO_IDX_A_PU)),
        .wdata_i    (wdata),
        .override_i (ovr_a),
        .pin_i      (port_a_pin_i),
        .pin_o      (port_a_pin_o),
        .pin_oe_o   (port_a_pin_oe_o),
        .pullup_o   (port_a_pullup_o),
        .rd_data_o  (a_data),
        .rd_dir_o   (a_dir),
        .rd_pu_o    (a_pu)
    );

    pio_port #(.WIDTH(`PIO_WIDTH_FULL), .HAS_PULLUP(0)) u_port_b (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wr_latch_i (pio_wr(wr_en, idx, `PIO_IDX_B_DATA)),
        .wr_dir_i   (pio_wr(wr_en, idx, `PIO_IDX_B_DIR)),
        .wr_pu_i    (1'b0),
        .wdata_i    (wdata),
        .override_i (ovr_b),
        .pin_i      (port_b_pin_i),
        .pin_o      (port_b_pin_o),
        .pin_oe_o   (port_b_pin_oe_o),
        .pullup_o   (),
        .rd_data_o  (b_data),
        .rd_dir_o   (b_dir),
        .rd_pu_o    ()
    );

    pio_port #(.WIDTH(`PIO_WIDTH_C), .HAS_PULLUP(1)) u_port_c (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wr_latch_i (pio_wr(wr_en, idx, `PIO_IDX_C_DATA)),
        .wr_dir_i   (pio_wr(wr_en, idx, `PIO_IDX_C_DIR)),
        .wr_pu_i    (pio_wr(wr_en, idx, `PIO_IDX_C_PU)),
        .wdata_i    (wdata),
        .override_i (7'h00),
        .pin_i      (port_c_pin_i),
        .pin_o      (port_c_pin_o),
        .pin_oe_o   (port_c_pin_oe_o),
        .pullup_o   (port_c_pullup_o),
        .rd_data_o  (c_data),
        .rd_dir_o   (c_dir),
        .rd_pu_o    (c_pu)
    );

    pio_port #(.WIDTH(`PIO_WIDTH_FULL), .HAS_PULLUP(1)) u_port_d (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wr_latch_i (pio_wr(wr_en, idx, `PIO_IDX_D_DATA)),
        .wr_dir_i   (pio_wr(wr_en, idx, `PIO_IDX_D_DIR)),
        .wr_pu_i    (pio_wr(wr_en, idx, `PIO_IDX_D_PU)),
        .wdata_i    (wdata),
        .override_i (8'h00),
        .pin_i      (port_d_pin_i),
        .pin_o      (port_d_pin_o),
        .pin_oe_o   (port_d_pin_oe_o),
        .pullup_o   (port_d_pullup_o),
        .rd_data_o  (d_data),
        .rd_dir_o   (d_dir),
        .rd_pu_o    (d_pu)
    );

    pio_port #(.WIDTH(`PIO_WIDTH_E), .HAS_PULLUP(0)) u_port_e (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wr_latch_i (pio_wr(wr_en, idx, `PIO_IDX_E_DATA)),
        .wr_dir_i   (pio_wr(wr_en, idx, `PIO_IDX_E_DIR)),
        .wr_pu_i    (1'b0),
        .wdata_i    (wdata),
        .override_i (6'h00),
        .pin_i      (port_e_pin_i),
        .pin_o      (port_e_pin_o),
        .pin_oe_o   (port_e_pin_oe_o),
        .pullup_o   (),
        .rd_data_o  (e_data),
        .rd_dir_o   (e_dir),
        .rd_pu_o    ()
    );

    pio_port #(.WIDTH(`PIO_WIDTH_FULL), .HAS_PULLUP(1)) u_port_f (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wr_latch_i (pio_wr(wr_en, idx, `PIO_IDX_F_DATA)),
        .wr_dir_i   (pio_wr(wr_en, idx, `PIO_IDX_F_DIR)),
        .wr_pu_i    (pio_wr(wr_en, idx, `PIO_IDX_F_PU)),
        .wdata_i    (wdata),
        .override_i (8'h00),
        .pin_i      (port_f_pin_i),
        .pin_o      (port_f_pin_o),
        .pin_oe_o   (port_f_pin_oe_o),
        .pullup_o   (port_f_pullup_o),
        .rd_data_o  (f_data),
        .rd_dir_o   (f_dir),
        .rd_pu_o    (f_pu)
    );

    pio_port #(.WIDTH(`PIO_WIDTH_FULL), .HAS_PULLUP(0)) u_port_g (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wr_latch_i (pio_wr(wr_en, idx, `PIO_IDX_G_DATA)),
        .wr_dir_i   (pio_wr(wr_en, idx, `PIO_IDX_G_DIR)),
        .wr_pu_i    (1'b0),
        .wdata_i    (wdata),
        .override_i (ovr_g),
        .pin_i      (port_g_pin_i),
        .pin_o      (port_g_pin_o),
        .pin_oe_o   (port_g_pin_oe_o),
        .pullup_o   (),
        .rd_data_o  (g_data),
        .rd_dir_o   (g_dir),
        .rd_pu_o    ()
    );

    // ****************************************************************
    // Read data mux
    // ****************************************************************
    always @* begin
        if (idx == `PIO_IDX_A_DATA) begin
            next_rdata = a_data;
        end else if (idx == `PIO_IDX_B_DATA) begin
            next_rdata = b_data;
        end else if (idx == `PIO_IDX_C_DATA) begin
            next_rdata = c_data;
        end else if (idx == `PIO_IDX_D_DATA) begin
            next_rdata = d_data;
        end else if (idx == `PIO_IDX_A_DIR) begin
            next_rdata = a_dir;
        end else if (idx == `PIO_IDX_B_DIR) begin
            next_rdata = b_dir;
        end else if (idx == `PIO_IDX_C_DIR) begin
            next_rdata = c_dir;
        end else if (idx == `PIO_IDX_D_DIR) begin
            next_rdata = d_dir;
        end else if (idx == `PIO_IDX_E_DATA) begin
            next_rdata = e_data;
        end else if (idx == `PIO_IDX_E_DIR) begin
            next_rdata = e_dir;
        end else if (idx == `PIO_IDX_A_PU) begin
            next_rdata = a_pu;
        end else if (idx == `PIO_IDX_C_PU) begin
            next_rdata = c_pu;
        end else if (idx == `PIO_IDX_D_PU) begin
            next_rdata = d_pu;
        end else if (idx == `PIO_IDX_F_DATA) begin
            next_rdata = f_data;
        end else if (idx == `PIO_IDX_G_DATA) begin
            next_rdata = g_data;
        end else if (idx == `PIO_IDX_F_DIR) begin
            next_rdata = f_dir;
        end else if (idx == `PIO_IDX_G_DIR) begin
            next_rdata = g_dir;
        end else if (idx == `PIO_IDX_F_PU) begin
            next_rdata = f_pu;
        end else begin
            next_rdata = 8'h00;
        end
    end

    // ****************************************************************
    // Acknowledge and read data register
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= {24'h00_0000, next_rdata};
            end
        end
    end

endmodule

//--- tb/parallel_io_ports_bench.sv
// Self-checking bench of the parallel port bank
module parallel_io_ports_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [13:0] DAT [7] = '{14'h000, 14'h001, 14'h002, 14'h003, 14'h008,
                                        14'h440, 14'h441};
    localparam logic [13:0] DIR [7] = '{14'h004, 14'h005, 14'h006, 14'h007, 14'h00c,
                                        14'h444, 14'h445};
    localparam logic [7:0]  MSK [7] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'h3f, 8'hff, 8'hff};
    localparam logic [13:0] PUI [4] = '{14'h00d, 14'h00e, 14'h00f, 14'h448};
    localparam int          PUP [4] = '{0, 2, 3, 5};
    localparam int          CVP [3] = '{1, 0, 6};
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [15:0] wb_adr_i = 16'h0000;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h1;
    logic conv_enable_i = 1'b0;
    logic [4:0] conv_channel_i = 5'h00;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire [7:0] po [7], oe [7], pu [7], lvl [7];
    logic [7:0] ext [7] = '{default: 8'h00}, ext_en [7] = '{default: 8'hff};
    logic [7:0] lat [7], dir [7];
    logic [15:0] lfsr = 16'h0c03;
    int fails = 0, checked = 0;

    always #2.5 clk_i = ~clk_i;

    // Pin bits that the design does not have stay quiet
    assign pu[1] = 8'h00;
    assign pu[4] = 8'h00;
    assign pu[6] = 8'h00;
    assign po[2][7] = 1'b0;
    assign oe[2][7] = 1'b0;
    assign pu[2][7] = 1'b0;
    assign po[4][7:6] = 2'b00;
    assign oe[4][7:6] = 2'b00;

    pio_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_enable_i(conv_enable_i),
        .conv_channel_i(conv_channel_i), .port_a_pin_i(lvl[0]), .port_a_pin_o(po[0]),
        .port_a_pin_oe_o(oe[0]), .port_a_pullup_o(pu[0]), .port_b_pin_i(lvl[1]),
        .port_b_pin_o(po[1]), .port_b_pin_oe_o(oe[1]), .port_c_pin_i(lvl[2][6:0]),
        .port_c_pin_o(po[2][6:0]), .port_c_pin_oe_o(oe[2][6:0]),
        .port_c_pullup_o(pu[2][6:0]), .port_d_pin_i(lvl[3]), .port_d_pin_o(po[3]),
        .port_d_pin_oe_o(oe[3]), .port_d_pullup_o(pu[3]), .port_e_pin_i(lvl[4][5:0]),
        .port_e_pin_o(po[4][5:0]), .port_e_pin_oe_o(oe[4][5:0]), .port_f_pin_i(lvl[5]),
        .port_f_pin_o(po[5]), .port_f_pin_oe_o(oe[5]), .port_f_pullup_o(pu[5]),
        .port_g_pin_i(lvl[6]), .port_g_pin_o(po[6]), .port_g_pin_oe_o(oe[6]));

    for (genvar p = 0; p < 7; p++) begin : g_brd
        pio_board u_brd (.clk_i(clk_i), .drv_i(po[p]), .oe_i(oe[p]), .pu_i(pu[p]),
            .ext_i(ext[p]), .ext_en_i(ext_en[p]), .level_o(lvl[p]));
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic finish_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wb(input logic we, input logic [13:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            check("ack", {7'h00, wb_ack_o}, 8'h01);
            finish_test();
        end else begin
            rd = wb_dat_o[7:0];
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i <= 1'b0;
        end
    endtask

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction

    function automatic logic [7:0] exp_read(int p);
        return ((lat[p] & dir[p]) | (ext[p] & ~dir[p])) & MSK[p];
    endfunction

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [7:0] v, x;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int p = 0; p < 7; p++) begin
            wb(0, DIR[p], 8'h00, v);
            check("dir reset", v, 8'h00);
        end
        for (int q = 0; q < 4; q++) begin
            wb(0, PUI[q], 8'h00, v);
            check("pullup reset", v, 8'h00);
        end
        $display("test reset values done");
        for (int r = 0; r < 4; r++) begin
            for (int p = 0; p < 7; p++) begin
                dir[p] = rnd();
                if (r == 0) dir[p] = 8'hff;
                lat[p] = rnd();
                x = rnd();
                ext[p] <= x;
                wb(1, DAT[p], lat[p], v);
                wb(1, DIR[p], dir[p], v);
            end
            repeat (4) @(posedge clk_i);
            for (int p = 0; p < 7; p++) begin
                wb(0, DIR[p], 8'h00, v);
                check("dir", v, dir[p] & MSK[p]);
                wb(0, DAT[p], 8'h00, v);
                check("data", v, exp_read(p));
                check("oe", oe[p] & MSK[p], dir[p] & MSK[p]);
                check("pin", po[p] & MSK[p], lat[p] & MSK[p]);
            end
        end
        wb(1, 14'h010, 8'h5a, v);
        wb(0, 14'h010, 8'h00, v);
        check("unmapped", v, 8'h00);
        $display("test data and direction done");
        for (int q = 0; q < 4; q++) begin
            dir[PUP[q]] = 8'h0f;
            wb(1, DIR[PUP[q]], 8'h0f, v);
            wb(1, PUI[q], 8'hff, v);
            ext_en[PUP[q]] <= 8'h00;
            repeat (4) @(posedge clk_i);
            check("pullup out", pu[PUP[q]] & MSK[PUP[q]], 8'hf0 & MSK[PUP[q]]);
            wb(0, PUI[q], 8'h00, v);
            check("pullup reg", v, MSK[PUP[q]]);
            wb(0, DAT[PUP[q]], 8'h00, v);
            check("pulled data", v, ((lat[PUP[q]] & 8'h0f) | 8'hf0) & MSK[PUP[q]]);
            dir[PUP[q]] = 8'h00;
            wb(1, DIR[PUP[q]], 8'h00, v);
            @(posedge clk_i);
            check("pullup back", pu[PUP[q]] & MSK[PUP[q]], MSK[PUP[q]]);
            ext_en[PUP[q]] <= 8'hff;
        end
        $display("test pullups done");
        for (int k = 0; k < 3; k++) begin
            wb(1, DIR[CVP[k]], 8'hff, v);
            dir[CVP[k]] = 8'hff;
            conv_enable_i <= 1'b1;
            conv_channel_i <= 5'(8 * k + 3);
            repeat (3) @(posedge clk_i);
            check("conv oe", oe[CVP[k]], 8'hf7);
            conv_enable_i <= 1'b0;
            repeat (3) @(posedge clk_i);
            check("conv off", oe[CVP[k]], 8'hff);
        end
        $display("test converter done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int p = 0; p < 7; p++) begin
            check("oe after reset", oe[p] & MSK[p], 8'h00);
            wb(1, DIR[p], 8'hff, v);
        end
        repeat (2) @(posedge clk_i);
        for (int p = 0; p < 7; p++) begin
            check("latch kept", po[p] & MSK[p], lat[p] & MSK[p]);
        end
        $display("test reset retention done");
        finish_test();
    end
endmodule

//--- tb/pio_board.sv
// Board side of one port: device drive, external drive, pullup, floating level
module pio_board (
    // Clock
    input  wire logic       clk_i,
    // Device side
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pu_i,
    // Board side
    input  wire logic [7:0] ext_i,
    input  wire logic [7:0] ext_en_i,
    output logic      [7:0] level_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] float_pat = 8'h00;
    always @(posedge clk_i) begin
        float_pat <= ~float_pat;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (oe_i[i] === 1'b1) level_o[i] = drv_i[i];
            else if (ext_en_i[i]) level_o[i] = ext_i[i];
            else if (pu_i[i] === 1'b1) level_o[i] = 1'b1;
            else level_o[i] = float_pat[i];
        end
    end
endmodule

//--- tb/pio_props.sv
// Concurrent checks on the port bank's bus answer and pin outputs
module pio_props (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Converter select
    input wire logic        conv_enable_i,
    input wire logic [4:0]  conv_channel_i,
    // Pins
    input wire logic [7:0]  port_a_pin_oe_o,
    input wire logic [7:0]  port_a_pullup_o,
    input wire logic [7:0]  port_b_pin_oe_o,
    input wire logic [6:0]  port_c_pin_oe_o,
    input wire logic [6:0]  port_c_pullup_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered one cycle later");
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_read_upper_zero: assert property (wb_dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_pullup_off_output: assert property (((port_a_pullup_o & port_a_pin_oe_o) == 8'h00) &&
        ((port_c_pullup_o & port_c_pin_oe_o) == 7'h00))
        else $error("pullup on while pin driven");
    a_reset_all_input: assert property ($fell(rst_i) |-> port_a_pin_oe_o == 8'h00 &&
        port_b_pin_oe_o == 8'h00 && port_c_pullup_o == 7'h00 ##1 port_c_pin_oe_o == 7'h00)
        else $error("pins not inputs after reset");
    a_conv_frees_a: assert property (conv_enable_i && conv_channel_i[4:3] == 2'b01 |=>
        !port_a_pin_oe_o[$past(conv_channel_i[2:0])])
        else $error("converter pin of port a still driven");
    a_conv_frees_b: assert property (conv_enable_i && conv_channel_i[4:3] == 2'b00 |=>
        !port_b_pin_oe_o[$past(conv_channel_i[2:0])])
        else $error("converter pin of port b still driven");

    c_write_ack: cover property (wb_cyc_i && wb_we_i ##1 wb_ack_o);
    c_conv_used: cover property (conv_enable_i && port_a_pin_oe_o == 8'hf7);
    c_pullup_on: cover property (port_a_pullup_o == 8'hf0);
endmodule

bind pio_top pio_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .conv_enable_i(conv_enable_i), .conv_channel_i(conv_channel_i),
    .port_a_pin_oe_o(port_a_pin_oe_o), .port_a_pullup_o(port_a_pullup_o),
    .port_b_pin_oe_o(port_b_pin_oe_o), .port_c_pin_oe_o(port_c_pin_oe_o),
    .port_c_pullup_o(port_c_pullup_o));
